// >>> design/mic_irq_ctrl.sv
// main file: interrupt controller with APB register slave
// Notes on behaviour
// - six maskable sources: port A, port C, A-and-C, prescaler, timer, serial buffer
// - cpu interrupt needs flag set, its mask one and global enable one
// - masks: one per port, two prescaler masks, one timer mask
// - initial reset clears every mask bit
// - halt sets global enable unless it starts automatic serial buffer transfer
// - reading main request register clears timer and prescaler flags
// - port flags clear only when their own port request register is read
// - taking interrupt clears global enable; software must set it again
// - requests during service stay pending and raise a new interrupt afterwards
// - timer and prescaler flags set regardless of their masks
// - prescaler interrupt tap selects 32, 8 or 1 Hz
// - main register: prescaler bit3, timer bit2, port C bit1, port A bit0
// - writing one to bit 2 of main register enters sleep when guard set
// - control bit 0 is global enable, resets to zero
// - control bit 1 selects debounce clock, short at zero, resets to zero
// - timer flag sets when the timer counter reaches zero
// - port control bit 0 selects and-combination of port A and C
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module mic_irq_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  port_a_evt,
  input  wire logic [3:0]  port_c_evt,
  input  wire logic        tick_32hz,
  input  wire logic        timer_zero,
  input  wire logic        swb_req,
  input  wire logic        swb_interactive,
  input  wire logic        halt_exec,
  input  wire logic        swb_auto_start,
  input  wire logic        swb_auto_busy,
  input  wire logic        irq_ack,
  input  wire logic        sleep_guard,
  output logic             cpu_irq,
  output logic             sleep_req,
  output logic             debounce_clock_select,
  output logic             swb_request_flag
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [3:0]  port_a_request_register;
    logic [3:0]  port_c_request_register;
    logic        port_a_request_flag;
    logic        port_c_request_flag;
    logic        timer_request_flag;
    logic        prescaler_request_flag;
    logic        swb_flag;
    logic        global_irq_enable;
    logic        debounce_clock_select;
    logic        port_and_combine_select;
    logic [6:0]  mask;
    logic [1:0]  tap_sel;
    logic        sleep;
    logic        irq;
    logic [31:0] rdata;
    logic [7:0]  pin_s1;
    logic [7:0]  pin_s2;
  } mic_st_s;

  mic_st_s   st_r;
  mic_st_s   st_nxt;
  mic_req_if rq ();

  mic_ps_tap mic_ps_tap_i (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick_32hz (tick_32hz),
    .rq        (rq.sel)
  );
  assign rq.tap_sel = st_r.tap_sel;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states, unmapped addresses answer with an error
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  assign access  = psel & penable;
  assign wr      = access & pwrite;
  assign rd      = access & ~pwrite;
  assign mapped  = (paddr == mic_pkg::MAIN_REQ_ADDR) || (paddr == mic_pkg::IRQ_CTRL_ADDR)
                || (paddr == mic_pkg::MASK_ADDR) || (paddr == mic_pkg::PORT_CTRL_ADDR)
                || (paddr == mic_pkg::PORT_A_REQ_ADDR) || (paddr == mic_pkg::PORT_C_REQ_ADDR);
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  logic rd_main;
  logic rd_pa;
  logic rd_pc;
  assign rd_main = rd && (paddr == mic_pkg::MAIN_REQ_ADDR);
  assign rd_pa   = rd && (paddr == mic_pkg::PORT_A_REQ_ADDR);
  assign rd_pc   = rd && (paddr == mic_pkg::PORT_C_REQ_ADDR);

  // masked request terms
  logic and_evt;
  logic any_masked;
  assign and_evt = st_r.port_and_combine_select & st_r.port_a_request_flag & st_r.port_c_request_flag;
  assign any_masked =
      (st_r.port_a_request_flag & st_r.mask[mic_pkg::MPA_BIT] & ~st_r.port_and_combine_select)
    | (st_r.port_c_request_flag & st_r.mask[mic_pkg::MPC_BIT] & ~st_r.port_and_combine_select)
    | (and_evt & st_r.mask[mic_pkg::MAND_BIT])
    | (st_r.prescaler_request_flag & (st_r.mask[mic_pkg::MPS0_BIT] | st_r.mask[mic_pkg::MPS1_BIT]))
    | (st_r.timer_request_flag & st_r.mask[mic_pkg::TIMER_REQUEST_MASK_BIT])
    | (st_r.swb_flag & st_r.mask[mic_pkg::MSWB_BIT]);

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic; flag sets are applied after read clears so they win; irq_ack clears enable last
  always_comb begin
    st_nxt       = st_r;
    st_nxt.sleep = 1'b0;
    st_nxt.rdata = 32'h0000_0000;
    // two-flop synchroniser for port events; only the second stage feeds logic
    st_nxt.pin_s1 = {port_c_evt, port_a_evt};
    st_nxt.pin_s2 = st_r.pin_s1;
    // port detail registers clear on their own read
    if (rd_pa) begin
      st_nxt.port_a_request_register = 4'h0;
      st_nxt.port_a_request_flag     = 1'b0;
    end
    if (rd_pc) begin
      st_nxt.port_c_request_register = 4'h0;
      st_nxt.port_c_request_flag     = 1'b0;
    end
    // read of main register clears timer and prescaler
    if (rd_main) begin
      st_nxt.timer_request_flag     = 1'b0;
      st_nxt.prescaler_request_flag = 1'b0;
    end
    st_nxt.port_a_request_register = st_nxt.port_a_request_register | st_r.pin_s2[3:0];
    st_nxt.port_c_request_register = st_nxt.port_c_request_register | st_r.pin_s2[7:4];
    if (|st_r.pin_s2[3:0]) begin
      st_nxt.port_a_request_flag = 1'b1;
    end
    if (|st_r.pin_s2[7:4]) begin
      st_nxt.port_c_request_flag = 1'b1;
    end
    // timer and prescaler flags set regardless of masks
    if (timer_zero) begin
      st_nxt.timer_request_flag = 1'b1;
    end
    if (rq.ps_tick) begin
      st_nxt.prescaler_request_flag = 1'b1;
    end
    // serial buffer source counts only in interactive mode
    st_nxt.swb_flag = swb_req & swb_interactive;
    // register writes
    if (wr) begin
      unique case (paddr)
        mic_pkg::MAIN_REQ_ADDR: begin
          // sleep request only when the guard allows it
          st_nxt.sleep = pwdata[mic_pkg::SLEEP_BIT] & sleep_guard;
        end
        mic_pkg::IRQ_CTRL_ADDR: begin
          st_nxt.global_irq_enable     = pwdata[mic_pkg::EN_BIT];
          st_nxt.debounce_clock_select = pwdata[mic_pkg::DEB_BIT];
        end
        mic_pkg::MASK_ADDR: begin
          st_nxt.mask    = pwdata[6:0];
          st_nxt.tap_sel = pwdata[9:8];
        end
        mic_pkg::PORT_CTRL_ADDR: begin
          st_nxt.port_and_combine_select = pwdata[mic_pkg::AND_BIT];
        end
        default: begin
        end
      endcase
    end
    // halt sets enable, except when it starts automatic transfer
    if (halt_exec && !swb_auto_start) begin
      st_nxt.global_irq_enable = 1'b1;
    end
    // taking an interrupt drops the enable
    if (irq_ack) begin
      st_nxt.global_irq_enable = 1'b0;
    end
    // one line, evaluated each cycle; blocked during automatic transfer
    // pending flags re-raise once software re-enables
    st_nxt.irq = any_masked & st_nxt.global_irq_enable & ~swb_auto_busy & ~irq_ack;
    // read data is registered; value presented in access phase is a setup-cycle snapshot
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        mic_pkg::MAIN_REQ_ADDR: st_nxt.rdata = {28'h000_0000, st_r.prescaler_request_flag,
                                  st_r.timer_request_flag, st_r.port_c_request_flag,
                                  st_r.port_a_request_flag};
        mic_pkg::IRQ_CTRL_ADDR: st_nxt.rdata = {30'h0000_0000, st_r.debounce_clock_select,
                                  st_r.global_irq_enable};
        mic_pkg::MASK_ADDR:     st_nxt.rdata = {22'h00_0000, st_r.tap_sel, 1'b0, st_r.mask};
        mic_pkg::PORT_CTRL_ADDR: st_nxt.rdata = {31'h0000_0000, st_r.port_and_combine_select};
        mic_pkg::PORT_A_REQ_ADDR: st_nxt.rdata = {28'h000_0000, st_r.port_a_request_register};
        mic_pkg::PORT_C_REQ_ADDR: st_nxt.rdata = {28'h000_0000, st_r.port_c_request_register};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  // masks and control clear on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= '0;
      st_r.mask <= mic_pkg::MASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata                = st_r.rdata;
  assign cpu_irq               = st_r.irq;
  assign sleep_req             = st_r.sleep;
  assign debounce_clock_select = st_r.debounce_clock_select;
  assign swb_request_flag      = st_r.swb_flag;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_main_read;
    psel && penable && !pwrite && (paddr == mic_pkg::MAIN_REQ_ADDR);
  endsequence
  sequence s_main_setup;
    psel && !penable && !pwrite && (paddr == mic_pkg::MAIN_REQ_ADDR);
  endsequence
  sequence s_ctrl_write;
    psel && penable && pwrite && (paddr == mic_pkg::IRQ_CTRL_ADDR);
  endsequence

  a_timer_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    s_main_read ##0 !timer_zero |=> !st_r.timer_request_flag)
    else $error("timer flag not cleared by main read");

  a_timer_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    timer_zero |=> st_r.timer_request_flag)
    else $error("timer event lost");

  a_port_flag_kept: assert property (@(posedge pclk) disable iff (!presetn)
    s_main_read ##0 st_r.port_a_request_flag |=> st_r.port_a_request_flag)
    else $error("port A flag cleared by main read");

  a_irq_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_irq |-> $past(st_nxt.global_irq_enable) && $past(any_masked))
    else $error("irq without enable or masked flag");

  a_ack_drops_enable: assert property (@(posedge pclk) disable iff (!presetn)
    irq_ack |=> !st_r.global_irq_enable && !cpu_irq)
    else $error("enable not cleared on acknowledge");

  a_halt_sets_enable: assert property (@(posedge pclk) disable iff (!presetn)
    halt_exec && !swb_auto_start && !irq_ack |=> st_r.global_irq_enable)
    else $error("halt did not set enable");

  a_sleep_guarded: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_req |-> $past(sleep_guard) && $past(wr))
    else $error("sleep without guard");

  a_prescaler_unmasked: assert property (@(posedge pclk) disable iff (!presetn)
    rq.ps_tick && st_r.mask == 7'h00 |=> st_r.prescaler_request_flag)
    else $error("prescaler flag gated by mask");

  a_irq_pending: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.global_irq_enable && !swb_auto_busy && !irq_ack && any_masked && !rd && !wr |=> cpu_irq)
    else $error("pending request not raised");

  // checked without disable so the first cycle after release is seen
  a_reset_clears: assert property (@(posedge pclk)
    $rose(presetn) |-> (st_r.mask == mic_pkg::MASK_RST) && !st_r.global_irq_enable && !st_r.debounce_clock_select)
    else $error("reset left a mask or control bit set");

  a_off_no_irq: assert property (@(posedge pclk) disable iff (!presetn)
    !st_r.global_irq_enable && !wr && !halt_exec |=> !cpu_irq)
    else $error("irq raised with enable off");

  a_unmasked_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !any_masked |=> !cpu_irq)
    else $error("irq raised without masked flag");

  a_busy_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    swb_auto_busy |=> !cpu_irq)
    else $error("irq raised during automatic transfer");

  a_halt_in_auto: assert property (@(posedge pclk) disable iff (!presetn)
    halt_exec && swb_auto_start && !st_r.global_irq_enable && !wr |=> !st_r.global_irq_enable)
    else $error("halt starting automatic transfer set enable");

  a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctrl_write ##0 (pwdata[mic_pkg::EN_BIT] && !irq_ack) |=> st_r.global_irq_enable)
    else $error("enable write of one lost");

  a_enable_clear: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctrl_write ##0 (!pwdata[mic_pkg::EN_BIT] && !halt_exec) |=> !st_r.global_irq_enable)
    else $error("enable write of zero lost");

  a_deb_set: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctrl_write ##0 pwdata[mic_pkg::DEB_BIT] |=> debounce_clock_select)
    else $error("debounce select not set");

  a_deb_clear: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctrl_write ##0 !pwdata[mic_pkg::DEB_BIT] |=> !debounce_clock_select)
    else $error("debounce select not cleared");

  a_main_layout: assert property (@(posedge pclk) disable iff (!presetn)
    s_main_setup |=> (prdata[31:4] == 28'h000_0000)
      && (prdata[mic_pkg::PR_BIT] == $past(st_r.prescaler_request_flag))
      && (prdata[mic_pkg::TE_BIT] == $past(st_r.timer_request_flag))
      && (prdata[mic_pkg::PC_BIT] == $past(st_r.port_c_request_flag))
      && (prdata[mic_pkg::PA_BIT] == $past(st_r.port_a_request_flag)))
    else $error("main request layout wrong");

  a_sleep_single: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_req |=> !sleep_req)
    else $error("sleep request wider than one cycle");

  a_port_a_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.pin_s2[3:0] != 4'h0) |=> st_r.port_a_request_flag)
    else $error("port A event lost");

  a_port_c_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.pin_s2[7:4] != 4'h0) |=> st_r.port_c_request_flag)
    else $error("port C event lost");

  a_port_a_clear: assert property (@(posedge pclk) disable iff (!presetn)
    rd_pa && (st_r.pin_s2[3:0] == 4'h0)
      |=> !st_r.port_a_request_flag && (st_r.port_a_request_register == 4'h0))
    else $error("port A read did not clear");

  a_ps_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    s_main_read ##0 !rq.ps_tick |=> !st_r.prescaler_request_flag)
    else $error("prescaler flag not cleared by main read");

  a_and_blocks_single: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.port_and_combine_select && !st_r.port_c_request_flag && !st_r.timer_request_flag
      && !st_r.prescaler_request_flag && !st_r.swb_flag |=> !cpu_irq)
    else $error("single port raised irq under and-select");

  a_tap_off: assert property (@(posedge pclk) disable iff (!presetn)
    (mic_pkg::mic_tap_e'(st_r.tap_sel) == mic_pkg::MIC_SEL_OFF) |=> !rq.ps_tick)
    else $error("prescaler event with tap off");

  a_tap_fast: assert property (@(posedge pclk) disable iff (!presetn)
    (mic_pkg::mic_tap_e'(st_r.tap_sel) == mic_pkg::MIC_SEL_32) && tick_32hz |=> rq.ps_tick)
    else $error("fast tap missed a base tick");

  a_swb_source: assert property (@(posedge pclk) disable iff (!presetn)
    swb_req && swb_interactive |=> swb_request_flag)
    else $error("serial buffer request lost");
endmodule

// >>> design/mic_pkg.sv
// package: register map, fields, reset values and timing constants of the interrupt controller
package mic_pkg;
  // register byte addresses on the APB bus
  localparam logic [7:0] MAIN_REQ_ADDR   = 8'h00;
  localparam logic [7:0] IRQ_CTRL_ADDR   = 8'h04;
  localparam logic [7:0] MASK_ADDR       = 8'h08;
  localparam logic [7:0] PORT_CTRL_ADDR  = 8'h0C;
  localparam logic [7:0] PORT_A_REQ_ADDR = 8'h10;
  localparam logic [7:0] PORT_C_REQ_ADDR = 8'h14;
  // main request register field positions
  localparam int PR_BIT    = 3;
  localparam int TE_BIT    = 2;
  localparam int PC_BIT    = 1;
  localparam int PA_BIT    = 0;
  localparam int SLEEP_BIT = 2;
  // control register field positions
  localparam int DEB_BIT   = 1;
  localparam int EN_BIT    = 0;
  // mask register field positions
  localparam int MPA_BIT   = 0;
  localparam int MPC_BIT   = 1;
  localparam int MPS0_BIT  = 2;
  localparam int MPS1_BIT  = 3;
  localparam int TIMER_REQUEST_MASK_BIT  = 4;
  localparam int MAND_BIT  = 5;
  localparam int MSWB_BIT  = 6;
  // port control field positions
  localparam int AND_BIT   = 0;
  // reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [6:0] MASK_RST = 7'h00;
  localparam logic [3:0] FLAG_RST = 4'h0;
  // prescaler: ticks enter at 32 Hz; taps divide to 8 Hz and 1 Hz
  localparam int PS_DIV_8  = 4;
  localparam int PS_DIV_1  = 32;
  localparam logic [4:0] PS_CNT_MAX = 5'h1F;
  typedef enum logic [1:0] {MIC_SEL_32, MIC_SEL_8, MIC_SEL_1, MIC_SEL_OFF} mic_tap_e;
endpackage

// >>> design/mic_ps_tap.sv
// prescaler tap selector: turns 32 Hz ticks into 32, 8 or 1 Hz interrupt events
`timescale 1ns/1ps
module mic_ps_tap (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic tick_32hz,
  mic_req_if.sel    rq
);
  typedef struct packed {
    logic [4:0] cnt;
    logic       tick;
  } mic_ps_s;
  mic_ps_s st_r;
  mic_ps_s st_nxt;

  // divide the base tick; counter wraps on its own every 32 ticks
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (tick_32hz) begin
      st_nxt.cnt = st_r.cnt + 5'h01;
      unique case (mic_pkg::mic_tap_e'(rq.tap_sel))
        mic_pkg::MIC_SEL_32: st_nxt.tick = 1'b1;
        mic_pkg::MIC_SEL_8:  st_nxt.tick = (st_r.cnt[1:0] == 2'(mic_pkg::PS_DIV_8 - 1));
        mic_pkg::MIC_SEL_1:  st_nxt.tick = (st_r.cnt == mic_pkg::PS_CNT_MAX);
        mic_pkg::MIC_SEL_OFF: st_nxt.tick = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rq.ps_tick = st_r.tick;
endmodule

// >>> design/mic_req_if.sv
// interface: prescaler tap request between the prescaler selector and the main controller
`timescale 1ns/1ps
interface mic_req_if;
  logic       ps_tick;
  logic [1:0] tap_sel;
  modport sel  (input tap_sel, output ps_tick);
  modport ctrl (output tap_sel, input ps_tick);
endinterface

// >>> verification/mic_cpu_model.sv
// cpu core stand-in: takes a pending interrupt after a chosen delay
`timescale 1ns/1ps
module mic_cpu_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       cpu_irq,
  input  wire logic       take,
  input  wire logic [3:0] lat,
  output logic            irq_ack
);
  logic [3:0] cnt_r;
  ////////////////////////////////////////////////////////////////////////
  // a slow core lets the line wait lat cycles; the ack is one cycle wide
  // take lets the model ack; the ack clears enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r   <= 4'h0;
      irq_ack <= 1'b0;
    end else begin
      irq_ack <= 1'b0;
      if (!take || cpu_irq !== 1'b1 || irq_ack) begin
        cnt_r <= 4'h0; // restart so one request gives one ack
      end else if (cnt_r >= lat) begin
        irq_ack <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule

// >>> verification/mic_irq_ctrl_tb.sv
// self-checking bench: register accesses and interrupt scenarios
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %0h expected %0h", $time, a, e); end end
module mic_irq_ctrl_tb;
  localparam logic [7:0] A_MN = mic_pkg::MAIN_REQ_ADDR;
  localparam logic [7:0] A_CT = mic_pkg::IRQ_CTRL_ADDR;
  localparam logic [7:0] A_MK = mic_pkg::MASK_ADDR;
  localparam logic [7:0] A_PT = mic_pkg::PORT_CTRL_ADDR;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        tick_32hz = 1'b0, timer_zero = 1'b0, swb_req = 1'b0, swb_interactive = 1'b0;
  logic        halt_exec = 1'b0, swb_auto_start = 1'b0, swb_auto_busy = 1'b0, sleep_guard = 1'b0;
  logic        take = 1'b0, pready, pslverr, irq_ack, cpu_irq, sleep_req, debounce_clock_select;
  logic        swb_request_flag, err_q;
  logic [3:0]  port_a_evt = 4'h0, port_c_evt = 4'h0, lat = 4'h3;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [6:0]  mk [7] = '{7'h10, 7'h04, 7'h08, 7'h01, 7'h02, 7'h0F, 7'h10};
  int          src [7] = '{1, 0, 0, 2, 3, 1, 1};
  int          pcount [4] = '{32, 8, 1, 0};
  int          mismatches = 0, comparisons = 0, acks = 0, slp = 0, n;

  mic_irq_ctrl mic_irq_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .port_a_evt, .port_c_evt, .tick_32hz, .timer_zero, .swb_req, .swb_interactive,
    .halt_exec, .swb_auto_start, .swb_auto_busy, .irq_ack, .sleep_guard, .cpu_irq, .sleep_req,
    .debounce_clock_select, .swb_request_flag);
  mic_cpu_model mic_cpu_model_i (.pclk, .presetn, .cpu_irq, .take, .lat, .irq_ack);

  always #20 pclk = ~pclk;
  // count acks and sleep cycles; a wide sleep pulse shows as a count above one
  always @(posedge pclk) begin
    if (irq_ack === 1'b1) acks++;
    if (sleep_req === 1'b1) slp++;
  end
  ////////////////////////////////////////////////////////////////////////
  // apb master: entered just after an edge, holds until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  // one-cycle event, then room for the two-flop sync and the registered line
  task automatic fire(input int s);
    case (s)
      0: tick_32hz <= 1'b1;
      1: timer_zero <= 1'b1;
      2: port_a_evt <= 4'h1;
      default: port_c_evt <= 4'h2;
    endcase
    @(posedge pclk);
    tick_32hz <= 1'b0;
    timer_zero <= 1'b0;
    port_a_evt <= 4'h0;
    port_c_evt <= 4'h0;
    repeat (4) @(posedge pclk);
  endtask
  // drain every flag and drop the enable between cases
  task automatic clean();
    apb(1'b0, A_MN, 32'h0);
    apb(1'b0, mic_pkg::PORT_A_REQ_ADDR, 32'h0);
    apb(1'b0, mic_pkg::PORT_C_REQ_ADDR, 32'h0);
    wr(A_CT, 32'h0);
  endtask
  task automatic halt();
    halt_exec <= 1'b1;
    @(posedge pclk);
    halt_exec <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // a hang costs far more than the 1500 or so cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(A_CT, 32'h0);
    rd(A_MK, 32'h0);
    rd(A_PT, 32'h0);
    rd(A_MN, 32'h0);
    wr(A_CT, 32'h2);
    `CHK(debounce_clock_select, 1'b1)
    rd(A_CT, 32'h2);
    wr(A_MK, 32'h37F);
    rd(A_MK, 32'h37F);
    wr(A_MK, 32'h0);
    rd(8'h1C, 32'h0);
    `CHK(err_q, 1'b1)
    clean();
    $display("test registers finished");
    // flags rise with every mask clear; only main-read-clearable ones drop
    fire(1);
    fire(0);
    fire(2);
    fire(3);
    `CHK(cpu_irq, 1'b0)
    rd(A_MN, 32'hF);
    rd(A_MN, 32'h3);
    rd(mic_pkg::PORT_A_REQ_ADDR, 32'h1);
    rd(A_MN, 32'h2);
    rd(mic_pkg::PORT_C_REQ_ADDR, 32'h2);
    rd(A_MN, 32'h0);
    $display("test flags finished");
    // rows 5 and 6: wrong mask, and right mask with the enable off
    for (int i = 0; i < 7; i++) begin
      wr(A_MK, {25'h0, mk[i]});
      wr(A_CT, (i < 6) ? 32'h1 : 32'h0);
      fire(src[i]);
      `CHK(cpu_irq, (i < 5) ? 1'b1 : 1'b0)
      clean();
    end
    wr(A_PT, 32'h1);
    wr(A_MK, 32'h21);
    wr(A_CT, 32'h1);
    fire(2);
    `CHK(cpu_irq, 1'b0)
    fire(3);
    `CHK(cpu_irq, 1'b1)
    clean();
    wr(A_PT, 32'h0);
    $display("test masks finished");
    // 32 base ticks hold an exact number of tap events whatever the phase
    for (int t = 0; t < 4; t++) begin
      wr(A_MK, 32'(t) << 8);
      n = 0;
      for (int k = 0; k < 32; k++) begin
        fire(0);
        apb(1'b0, A_MN, 32'h0);
        if (q[mic_pkg::PR_BIT] === 1'b1) n++;
      end
      `CHK(n, pcount[t])
    end
    wr(A_MK, 32'h0);
    $display("test prescaler finished");
    swb_auto_start <= 1'b1;
    halt();
    rd(A_CT, 32'h0);
    swb_auto_start <= 1'b0;
    halt();
    rd(A_CT, 32'h1);
    wr(A_CT, 32'h0);
    $display("test halt finished");
    take <= 1'b1;
    wr(A_MK, 32'h10);
    wr(A_CT, 32'h1);
    fire(1);
    repeat (8) @(posedge pclk);
    `CHK(acks, 1)
    rd(A_CT, 32'h0);
    rd(A_MN, 32'h4);
    lat <= 4'h1;
    fire(1);
    `CHK(cpu_irq, 1'b0)
    wr(A_CT, 32'h1); // software re-enables
    repeat (8) @(posedge pclk);
    `CHK(acks, 2)
    rd(A_MN, 32'h4);
    take <= 1'b0;
    clean();
    $display("test service finished");
    // event lands on the very edge where the read clears the flag
    fork
      apb(1'b0, A_MN, 32'h0);
      begin
        @(posedge pclk);
        timer_zero <= 1'b1;
        @(posedge pclk);
        timer_zero <= 1'b0;
      end
    join
    rd(A_MN, 32'h4);
    sleep_guard <= 1'b1; // guard before the write
    wr(A_MN, 32'h4);
    repeat (3) @(posedge pclk);
    `CHK(slp, 1)
    sleep_guard <= 1'b0;
    wr(A_MN, 32'h4);
    repeat (3) @(posedge pclk);
    `CHK(slp, 1)
    swb_interactive <= 1'b1;
    swb_req <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK(swb_request_flag, 1'b1)
    wr(A_MK, 32'h40);
    wr(A_CT, 32'h1);
    `CHK(cpu_irq, 1'b1)
    // an automatic transfer holds the line down while it runs
    swb_auto_busy <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK(cpu_irq, 1'b0)
    swb_auto_busy <= 1'b0;
    swb_interactive <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK(swb_request_flag, 1'b0)
    `CHK(cpu_irq, 1'b0)
    $display("test misc finished");
    finish_test();
  end
endmodule
